// ===== src/pmu_params.svh
// constants for the converter sequencer and event request unit
// assumes a 100 MHz system clock and an i2c-style register link
`ifndef PMU_PARAMS_SVH
`define PMU_PARAMS_SVH

`define CLK_PERIOD_NS  10
`define NS_PER_MS      1000000
`define WARMUP_MS      2
`define CONV_MS        4
`define MS_TO_CYC(ms)  ((ms) * `NS_PER_MS / `CLK_PERIOD_NS)
`define SEQ_CNT_W      20

`define OFS_CONV_CTRL  8'h0A
`define OFS_RESULT     8'h0B
`define OFS_MASK       8'h0C
`define OFS_FLAGS      8'h0D
`define REG_RESET      8'h00
`define READ_UNMAPPED  8'h00
`define CTRL_WR_MASK   8'hCF

`define CC_VRANGE      7
`define CC_IRANGE      6
`define CC_OVF         5
`define CC_RDY         4
`define CC_START       3
`define CC_EN          2
`define CC_SRC_HI      1
`define CC_SRC_LO      0

`define EV_ADAPTER_ON  0
`define EV_ADAPTER_OFF 1
`define EV_USB_ON      2
`define EV_USB_OFF     3
`define EV_BAT_LOW     4
`define EV_THERMAL     5
`define EV_CONV_DONE   6
`define EV_TIMEOUT     7

`define LV_ADAPTER     0
`define LV_USB         1
`define LV_BAT_LOW     2
`define LV_THERMAL     3
`define LV_TIMEOUT     4

// slave address on the link; arbitrary value
`define LINK_DEV_ADDR  7'h3A
`define BYTE_BITS      4'h8

`endif

// ===== src/pmu_pkg.sv
// types shared by the converter sequencer and event request unit
// assumes pmu_params.svh for the widths of its fields
`include "pmu_params.svh"
package pmu_pkg;
	typedef enum logic [3:0] {
		I2C_IDLE, I2C_ADDR, I2C_AACK, I2C_REG, I2C_RACK,
		I2C_WDAT, I2C_WACK, I2C_RDAT, I2C_MACK
	} link_state_t;

	typedef enum logic [1:0] {CV_IDLE, CV_WARM, CV_CONV} conv_state_t;

	typedef struct packed {
		link_state_t st;
		logic [3:0]  cnt;
		logic [7:0]  sh;
		logic        rw;
		logic [7:0]  ptr;
		logic        sda_oe_n;
		logic        scl_q;
		logic        sda_q;
		logic [7:0]  ctrl;
		logic [7:0]  result;
		logic [7:0]  mask;
		logic        req_oe_n;
		logic        pin_lo;
	} top_state_t;

	typedef struct packed {
		conv_state_t           st;
		logic [`SEQ_CNT_W-1:0] cnt;
		logic                  warmed;
		logic                  start_q;
		logic                  done;
		logic [7:0]            code;
		logic                  ovf;
	} seq_state_t;

	typedef struct packed {
		logic [4:0] prev;
		logic [7:0] pend;
		logic [7:0] flags;
	} ev_state_t;
endpackage

// ===== src/conv_if.sv
// control and result signals between the top and the converter sequencer
// assumes both ends run on the system clock
`timescale 1ns/10ps
`default_nettype none
interface conv_if;
	logic       enable;
	logic       start;
	logic [7:0] adc_code;
	logic       adc_ovf;
	logic       done;
	logic [7:0] code;
	logic       ovf;
	modport ctl (output enable, start, adc_code, adc_ovf,
		input done, code, ovf);
	modport seq (input enable, start, adc_code, adc_ovf,
		output done, code, ovf);
endinterface
`default_nettype wire

// ===== src/conv_sequencer.sv
// warm-up and conversion timing of the converter
// assumes the analog core presents its code and overflow at the end
`timescale 1ns/10ps
`default_nettype none
`include "pmu_params.svh"
module conv_sequencer #(
	parameter int WARMUP_CYCLES = `MS_TO_CYC(`WARMUP_MS),
	parameter int CONV_CYCLES   = `MS_TO_CYC(`CONV_MS)
) (
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	conv_if.seq       cv
);
	pmu_pkg::seq_state_t cur;
	pmu_pkg::seq_state_t nxt;

	localparam logic [`SEQ_CNT_W-1:0] WARM_LAST =
		`SEQ_CNT_W'(WARMUP_CYCLES - 1);
	localparam logic [`SEQ_CNT_W-1:0] CONV_LAST =
		`SEQ_CNT_W'(CONV_CYCLES - 1);

	assign cv.done = cur.done;
	assign cv.code = cur.code;
	assign cv.ovf  = cur.ovf;

	always_comb
	begin
		nxt         = cur;
		nxt.done    = 1'b0;
		nxt.start_q = cv.start;
		// dropping enable forgets warm-up, so re-enabling pays it again
		if (!cv.enable)
		begin
			nxt.st     = pmu_pkg::CV_IDLE;
			nxt.warmed = 1'b0;
			nxt.cnt    = '0;
		end
		else
		begin
			case (cur.st)
			pmu_pkg::CV_IDLE:
				if (cv.start && !cur.start_q)
				begin
					nxt.cnt = '0;
					nxt.st  = cur.warmed ? pmu_pkg::CV_CONV
						: pmu_pkg::CV_WARM;
				end
			pmu_pkg::CV_WARM:
				if (cur.cnt == WARM_LAST)
				begin
					nxt.cnt    = '0;
					nxt.warmed = 1'b1;
					nxt.st     = pmu_pkg::CV_CONV;
				end
				else
					nxt.cnt = cur.cnt + 1'b1;
			pmu_pkg::CV_CONV:
				// fixed worst-case time; a shorter analog phase is not seen
				if (cur.cnt == CONV_LAST)
				begin
					nxt.done = 1'b1;
					nxt.code = cv.adc_code;
					nxt.ovf  = cv.adc_ovf;
					nxt.st   = pmu_pkg::CV_IDLE;
				end
				else
					nxt.cnt = cur.cnt + 1'b1;
			default:
				nxt.st = pmu_pkg::CV_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			cur <= '0;
		else
			cur <= nxt;
	end

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	a_off_stays_idle: assert property (
		!cv.enable |=> cur.st == pmu_pkg::CV_IDLE && !cur.done)
		else $error("converter ran while disabled");
	a_rise_starts: assert property (
		cv.enable && cur.st == pmu_pkg::CV_IDLE && cv.start
		&& !cur.start_q |=> cur.st != pmu_pkg::CV_IDLE || !cv.enable)
		else $error("start edge did not begin a conversion");
endmodule
`default_nettype wire

// ===== src/event_capture.sv
// edge capture of the five level inputs plus the conversion-done pulse into eight flags with a pending buffer
// assumes level inputs synchronous to the system clock
`timescale 1ns/10ps
`default_nettype none
`include "pmu_params.svh"
module event_capture (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	input  wire logic       adapter_input_i,
	input  wire logic       usb_power_i,
	input  wire logic       battery_low_i,
	input  wire logic       thermal_alarm_i,
	input  wire logic       charge_timeout_i,
	input  wire logic       conv_done_i,
	input  wire logic       clear_i,
	output logic      [7:0] flags_o
);
	pmu_pkg::ev_state_t cur;
	pmu_pkg::ev_state_t nxt;
	logic [4:0] lv;
	logic [7:0] ev;

	assign lv[`LV_ADAPTER] = adapter_input_i;
	assign lv[`LV_USB]     = usb_power_i;
	assign lv[`LV_BAT_LOW] = battery_low_i;
	assign lv[`LV_THERMAL] = thermal_alarm_i;
	assign lv[`LV_TIMEOUT] = charge_timeout_i;
	assign flags_o         = cur.flags;

	always_comb
	begin
		ev = '0;
		ev[`EV_ADAPTER_ON]  = lv[`LV_ADAPTER] & ~cur.prev[`LV_ADAPTER];
		ev[`EV_ADAPTER_OFF] = ~lv[`LV_ADAPTER] & cur.prev[`LV_ADAPTER];
		ev[`EV_USB_ON]      = lv[`LV_USB] & ~cur.prev[`LV_USB];
		ev[`EV_USB_OFF]     = ~lv[`LV_USB] & cur.prev[`LV_USB];
		ev[`EV_BAT_LOW]     = lv[`LV_BAT_LOW] & ~cur.prev[`LV_BAT_LOW];
		ev[`EV_THERMAL]     = lv[`LV_THERMAL] & ~cur.prev[`LV_THERMAL];
		ev[`EV_CONV_DONE]   = conv_done_i;
		ev[`EV_TIMEOUT]     = lv[`LV_TIMEOUT] & ~cur.prev[`LV_TIMEOUT];
		nxt      = cur;
		nxt.prev = lv;
		// capture runs with no gating, so standby loses nothing
		if (clear_i)
		begin
			nxt.flags = '0;
			nxt.pend  = ev;
		end
		else
		begin
			nxt.flags = cur.flags | cur.pend | ev;
			nxt.pend  = '0;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			cur <= '0;
		else
			cur <= nxt;
	end

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	a_read_clears: assert property (
		clear_i |=> flags_o == 8'h00)
		else $error("flags not cleared by read");
	a_pending_moves: assert property (
		clear_i && ev != 8'h00 ##1 !clear_i
		|=> (flags_o & $past(ev, 2)) == $past(ev, 2))
		else $error("pending event lost");
	a_flags_sticky: assert property (
		!clear_i |=> (flags_o & $past(flags_o)) == $past(flags_o))
		else $error("flag dropped without a read");
	a_adapter_flag: assert property (
		$rose(adapter_input_i) && !clear_i |=> flags_o[`EV_ADAPTER_ON])
		else $error("adapter attach not flagged");
endmodule
`default_nettype wire

// ===== src/adc_sequencer_and_irq_unit.sv
// register link slave, converter control and request line of the unit
// assumes scl and sda already synchronous; the pad resolves open drain
`timescale 1ns/10ps
`default_nettype none
`include "pmu_params.svh"
module adc_sequencer_and_irq_unit #(
	parameter int WARMUP_CYCLES = `MS_TO_CYC(`WARMUP_MS),
	parameter int CONV_CYCLES   = `MS_TO_CYC(`CONV_MS)
) (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_n_o,
	output logic            request_out_n_o,
	output logic            request_oe_n_o,
	input  wire logic       adapter_input_i,
	input  wire logic       usb_power_i,
	input  wire logic       battery_low_i,
	input  wire logic       thermal_alarm_i,
	input  wire logic       charge_timeout_i,
	input  wire logic [7:0] adc_code_i,
	input  wire logic       adc_overflow_i,
	output logic            adc_enable_o,
	output logic      [1:0] adc_source_o,
	output logic            v_range_o,
	output logic            i_range_o
);
	pmu_pkg::top_state_t cur;
	pmu_pkg::top_state_t nxt;
	logic [7:0] flags;
	logic [7:0] rbyte;
	logic       flags_clear;
	logic       scl_rise;
	logic       scl_fall;
	logic       bus_start;
	logic       bus_stop;
	logic       start_wr;
	conv_if     cv ();

	// ------------------------------------------------------------
	// register read decode
	// ------------------------------------------------------------
	function automatic logic [7:0] reg_read(
		input logic [7:0] addr,
		input logic [7:0] ctrl,
		input logic [7:0] result,
		input logic [7:0] mask,
		input logic [7:0] flg
	);
		if (addr == `OFS_CONV_CTRL)
			reg_read = ctrl;
		else if (addr == `OFS_RESULT)
			reg_read = result;
		else if (addr == `OFS_MASK)
			reg_read = mask;
		else if (addr == `OFS_FLAGS)
			reg_read = flg;
		else
			reg_read = `READ_UNMAPPED;
	endfunction

	// ------------------------------------------------------------
	// sub-blocks
	// ------------------------------------------------------------
	assign cv.enable   = cur.ctrl[`CC_EN];
	assign cv.start    = cur.ctrl[`CC_START];
	assign cv.adc_code = adc_code_i;
	assign cv.adc_ovf  = adc_overflow_i;

	conv_sequencer #(
		.WARMUP_CYCLES (WARMUP_CYCLES),
		.CONV_CYCLES   (CONV_CYCLES)
	) u_seq (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.cv        (cv.seq)
	);

	event_capture u_ev (
		.clk_sys_i        (clk_sys_i),
		.rst_i            (rst_i),
		.adapter_input_i  (adapter_input_i),
		.usb_power_i      (usb_power_i),
		.battery_low_i    (battery_low_i),
		.thermal_alarm_i  (thermal_alarm_i),
		.charge_timeout_i (charge_timeout_i),
		.conv_done_i      (cv.done),
		.clear_i          (flags_clear),
		.flags_o          (flags)
	);

	// ------------------------------------------------------------
	// outputs, all straight from the state register
	// ------------------------------------------------------------
	assign sda_o           = cur.pin_lo;
	assign sda_oe_n_o      = cur.sda_oe_n;
	assign request_out_n_o = cur.pin_lo;
	assign request_oe_n_o  = cur.req_oe_n;
	assign adc_enable_o    = cur.ctrl[`CC_EN];
	assign adc_source_o    = cur.ctrl[`CC_SRC_HI:`CC_SRC_LO];
	assign v_range_o       = cur.ctrl[`CC_VRANGE];
	assign i_range_o       = cur.ctrl[`CC_IRANGE];

	assign scl_rise  = scl_i & ~cur.scl_q;
	assign scl_fall  = ~scl_i & cur.scl_q;
	assign bus_start = scl_i & cur.scl_q & cur.sda_q & ~sda_i;
	assign bus_stop  = scl_i & cur.scl_q & ~cur.sda_q & sda_i;
	assign rbyte     = reg_read(cur.ptr, cur.ctrl, cur.result,
		cur.mask, flags);
	// decoded only for the checks: a start edge written to control
	assign start_wr  = cur.st == pmu_pkg::I2C_WDAT && scl_fall
		&& cur.cnt == `BYTE_BITS && cur.ptr == `OFS_CONV_CTRL
		&& cur.sh[`CC_START] && !cur.ctrl[`CC_START];

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		nxt         = cur;
		flags_clear = 1'b0;
		nxt.scl_q   = scl_i;
		nxt.sda_q   = sda_i;
		nxt.pin_lo  = 1'b0;
		nxt.req_oe_n = ~|(flags & cur.mask);
		if (bus_start)
		begin
			nxt.st       = pmu_pkg::I2C_ADDR;
			nxt.cnt      = '0;
			nxt.sda_oe_n = 1'b1;
		end
		else if (bus_stop)
		begin
			nxt.st       = pmu_pkg::I2C_IDLE;
			nxt.sda_oe_n = 1'b1;
		end
		else
		begin
			if (scl_rise && (cur.st == pmu_pkg::I2C_ADDR
				|| cur.st == pmu_pkg::I2C_REG
				|| cur.st == pmu_pkg::I2C_WDAT))
			begin
				nxt.sh  = {cur.sh[6:0], sda_i};
				nxt.cnt = cur.cnt + 4'h1;
			end
			case (cur.st)
			pmu_pkg::I2C_ADDR:
				if (scl_fall && cur.cnt == `BYTE_BITS)
				begin
					if (cur.sh[7:1] == `LINK_DEV_ADDR)
					begin
						nxt.rw       = cur.sh[0];
						nxt.sda_oe_n = 1'b0;
						nxt.st       = pmu_pkg::I2C_AACK;
					end
					else
						nxt.st = pmu_pkg::I2C_IDLE;
				end
			pmu_pkg::I2C_REG:
				if (scl_fall && cur.cnt == `BYTE_BITS)
				begin
					nxt.ptr      = cur.sh;
					nxt.sda_oe_n = 1'b0;
					nxt.st       = pmu_pkg::I2C_RACK;
				end
			pmu_pkg::I2C_WDAT:
				if (scl_fall && cur.cnt == `BYTE_BITS)
				begin
					if (cur.ptr == `OFS_CONV_CTRL)
					begin
						// status bits stay under hardware control
						nxt.ctrl = (cur.sh & `CTRL_WR_MASK)
							| (cur.ctrl & ~`CTRL_WR_MASK);
						if (cur.sh[`CC_START] && !cur.ctrl[`CC_START])
						begin
							nxt.ctrl[`CC_RDY] = 1'b0;
							nxt.ctrl[`CC_OVF] = 1'b0;
						end
					end
					else if (cur.ptr == `OFS_MASK)
						nxt.mask = cur.sh;
					nxt.ptr      = cur.ptr + 8'h01;
					nxt.sda_oe_n = 1'b0;
					nxt.st       = pmu_pkg::I2C_WACK;
				end
			pmu_pkg::I2C_AACK, pmu_pkg::I2C_MACK:
				if (scl_rise && cur.st == pmu_pkg::I2C_MACK && sda_i)
					nxt.st = pmu_pkg::I2C_IDLE;
				else if (scl_fall)
				begin
					nxt.cnt = '0;
					if (cur.st == pmu_pkg::I2C_MACK || cur.rw)
					begin
						// flags clear in the cycle they are copied out
						flags_clear  = cur.ptr == `OFS_FLAGS;
						nxt.sh       = rbyte;
						nxt.sda_oe_n = rbyte[7];
						nxt.ptr      = cur.ptr + 8'h01;
						nxt.st       = pmu_pkg::I2C_RDAT;
					end
					else
					begin
						nxt.sda_oe_n = 1'b1;
						nxt.st       = pmu_pkg::I2C_REG;
					end
				end
			pmu_pkg::I2C_RACK, pmu_pkg::I2C_WACK:
				if (scl_fall)
				begin
					nxt.sda_oe_n = 1'b1;
					nxt.cnt      = '0;
					nxt.st       = pmu_pkg::I2C_WDAT;
				end
			pmu_pkg::I2C_RDAT:
				if (scl_rise)
					nxt.cnt = cur.cnt + 4'h1;
				else if (scl_fall && cur.cnt == `BYTE_BITS)
				begin
					nxt.sda_oe_n = 1'b1;
					nxt.st       = pmu_pkg::I2C_MACK;
				end
				else if (scl_fall)
				begin
					nxt.sh       = {cur.sh[6:0], 1'b0};
					nxt.sda_oe_n = cur.sh[6];
				end
			default:
				nxt.st = pmu_pkg::I2C_IDLE;
			endcase
		end
		// completion wins over a clearing start in the same cycle
		if (cv.done)
		begin
			nxt.result        = cv.code;
			nxt.ctrl[`CC_RDY] = 1'b1;
			nxt.ctrl[`CC_OVF] = cv.ovf;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cur          <= '0;
			cur.ctrl     <= `REG_RESET;
			cur.result   <= `REG_RESET;
			cur.mask     <= `REG_RESET;
			cur.sda_oe_n <= 1'b1;
			cur.req_oe_n <= 1'b1;
			cur.scl_q    <= 1'b1;
			cur.sda_q    <= 1'b1;
		end
		else
			cur <= nxt;
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	a_result_capture: assert property (
		cv.done |=> cur.result == $past(cv.code) && cur.ctrl[`CC_RDY])
		else $error("result or ready not taken at completion");
	a_done_raises_flag: assert property (
		cv.done && !flags_clear |=> flags[`EV_CONV_DONE])
		else $error("conversion done did not flag");
	a_request_drives: assert property (
		(flags & cur.mask) != 8'h00 |=> !request_oe_n_o)
		else $error("unmasked flag did not pull request");
	a_request_release: assert property (
		(flags & cur.mask) == 8'h00 |=> request_oe_n_o)
		else $error("request held with no unmasked flag");
	a_masked_silent: assert property (
		(flags & ~cur.mask) != 8'h00 && (flags & cur.mask) == 8'h00
		|=> request_oe_n_o && (flags & ~$past(cur.mask)) != 8'h00
		|| $past(flags_clear))
		else $error("masked source pulled request or was lost");

	// ------------------------------------------------------------
	// register checks
	// ------------------------------------------------------------
	a_result_hold: assert property (
		!cv.done |=> cur.result == $past(cur.result))
		else $error("result changed without a conversion");
	a_ready_source: assert property (
		!cv.done && !cur.ctrl[`CC_RDY] |=> !cur.ctrl[`CC_RDY])
		else $error("ready set without a completion");
	a_ovf_capture: assert property (
		cv.done |=> cur.ctrl[`CC_OVF] == $past(cv.ovf))
		else $error("overflow not taken at completion");
	a_mask_hold: assert property (
		cur.st != pmu_pkg::I2C_WDAT |=> cur.mask == $past(cur.mask))
		else $error("mask changed outside a data byte");
	a_ctrl_hold: assert property (
		cur.st != pmu_pkg::I2C_WDAT && !cv.done
		|=> cur.ctrl == $past(cur.ctrl))
		else $error("control changed with no write or completion");
	a_start_clears: assert property (
		start_wr && !cv.done
		|=> !cur.ctrl[`CC_RDY] && !cur.ctrl[`CC_OVF])
		else $error("start edge left stale ready or overflow");
endmodule
`default_nettype wire

// ===== test/link_host.sv
// host processor model: drives the register link as its master
// assumes a pull-up on sda; the bench resolves the wire
`timescale 1ns/10ps
`default_nettype none
`include "pmu_params.svh"
module link_host #(
	parameter logic [6:0] DEV = `LINK_DEV_ADDR
) (
	input  wire logic clk_sys_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_oe_n_o
);
	// four clocks per phase: the slave sees a level one clock after it changes
	localparam int HALF = 4;
	initial
	begin
		scl_o = 1'b1;
		sda_oe_n_o = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	task automatic bit_io(input logic b, output logic r);
		tick(1);
		sda_oe_n_o = b;
		tick(HALF);
		scl_o = 1'b1;
		tick(HALF / 2);
		r = sda_i;
		tick(HALF / 2);
		scl_o = 1'b0;
	endtask
	task automatic start_c();
		tick(1);
		sda_oe_n_o = 1'b1;
		tick(HALF);
		scl_o = 1'b1;
		tick(HALF);
		sda_oe_n_o = 1'b0;
		tick(HALF);
		scl_o = 1'b0;
	endtask
	task automatic stop_c();
		tick(1);
		sda_oe_n_o = 1'b0;
		tick(HALF);
		scl_o = 1'b1;
		tick(HALF);
		sda_oe_n_o = 1'b1;
		tick(HALF);
	endtask
	task automatic xfer(input logic [7:0] tx, input logic ak,
		output logic [7:0] rx);
		logic a;
		for (int i = 7; i >= 0; i--)
			bit_io(tx[i], rx[i]);
		bit_io(ak, a);
	endtask
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] x;
		start_c();
		xfer({DEV, 1'b0}, 1'b1, x);
		xfer(a, 1'b1, x);
		xfer(d, 1'b1, x);
		stop_c();
	endtask
	// single byte read ends with a master nack
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] x;
		start_c();
		xfer({DEV, 1'b0}, 1'b1, x);
		xfer(a, 1'b1, x);
		start_c();
		xfer({DEV, 1'b1}, 1'b1, x);
		xfer(8'hFF, 1'b1, d);
		stop_c();
	endtask
endmodule
`default_nettype wire

// ===== test/adc_sequencer_and_irq_unit_tb_top.sv
// self-checking bench of the converter sequencer and request unit
// assumes the host model owns the link; short warm-up and conversion
`timescale 1ns/10ps
`default_nettype none
`include "pmu_params.svh"
module adc_sequencer_and_irq_unit_tb_top;
	typedef struct packed {
		logic [4:0] lv;
		logic [7:0] flg;
		logic       req_n;
	} row_t;
	logic       clk_sys_i;
	logic       rst_i;
	logic       scl;
	logic       host_oe_n;
	logic       sda_o;
	logic       sda_oe_n;
	logic       req_o;
	logic       req_oe_n;
	logic [4:0] lv;
	logic [7:0] adc_code;
	logic       adc_ovf;
	logic       adc_en;
	logic [1:0] adc_src;
	logic       v_rng;
	logic       i_rng;
	logic [7:0] rd;
	int         fails;
	int         n_tests;
	row_t       rows [8];
	wire logic  sda_line = !host_oe_n ? 1'b0 : (!sda_oe_n ? sda_o : 1'b1);
	wire logic  irq_line = !req_oe_n ? req_o : 1'b1;

	adc_sequencer_and_irq_unit #(.WARMUP_CYCLES(5), .CONV_CYCLES(10)) u_dut (
		.clk_sys_i       (clk_sys_i),
		.rst_i           (rst_i),
		.scl_i           (scl),
		.sda_i           (sda_line),
		.sda_o           (sda_o),
		.sda_oe_n_o      (sda_oe_n),
		.request_out_n_o (req_o),
		.request_oe_n_o  (req_oe_n),
		.adapter_input_i (lv[0]),
		.usb_power_i     (lv[1]),
		.battery_low_i   (lv[2]),
		.thermal_alarm_i (lv[3]),
		.charge_timeout_i(lv[4]),
		.adc_code_i      (adc_code),
		.adc_overflow_i  (adc_ovf),
		.adc_enable_o    (adc_en),
		.adc_source_o    (adc_src),
		.v_range_o       (v_rng),
		.i_range_o       (i_rng)
	);
	link_host u_host (
		.clk_sys_i (clk_sys_i),
		.sda_i     (sda_line),
		.scl_o     (scl),
		.sda_oe_n_o(host_oe_n)
	);
	initial
	begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		u_host.read_reg(a, rd);
		check(rd, e);
	endtask
	task automatic wait_irq(input logic l);
		int k;
		k = 0;
		while (irq_line !== l && k < 5000)
		begin
			@(negedge clk_sys_i);
			k++;
		end
		check({7'h00, irq_line}, {7'h00, l});
	endtask
	task automatic summarize();
		if (fails == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		repeat (40000) @(posedge clk_sys_i);
		fails++;
		summarize();
	end
	initial
	begin
		rst_i = 1'b1;
		lv = 5'h00;
		adc_code = 8'hA5;
		adc_ovf = 1'b0;
		// levels: {timeout, thermal, battery low, usb, adapter}
		rows[0] = '{5'h01, 8'h01, 1'b1};
		rows[1] = '{5'h00, 8'h02, 1'b0};
		rows[2] = '{5'h02, 8'h04, 1'b1};
		rows[3] = '{5'h00, 8'h08, 1'b0};
		rows[4] = '{5'h04, 8'h10, 1'b1};
		rows[5] = '{5'h0C, 8'h20, 1'b0};
		rows[6] = '{5'h1C, 8'h80, 1'b0};
		rows[7] = '{5'h1F, 8'h05, 1'b1};
		repeat (3) @(negedge clk_sys_i);
		rst_i = 1'b0;
		repeat (3) @(negedge clk_sys_i);
		check({7'h00, irq_line}, 8'h01);
		rdc(`OFS_CONV_CTRL, 8'h00);
		rdc(`OFS_RESULT, 8'h00);
		rdc(`OFS_MASK, 8'h00);
		rdc(`OFS_FLAGS, 8'h00);
		rdc(8'h0E, 8'h00);
		u_host.write_reg(`OFS_MASK, 8'hAA);
		rdc(`OFS_MASK, 8'hAA);
		foreach (rows[i])
		begin
			lv = rows[i].lv;
			repeat (3) @(negedge clk_sys_i);
			check({7'h00, irq_line}, {7'h00, rows[i].req_n});
			rdc(`OFS_FLAGS, rows[i].flg);
			rdc(`OFS_FLAGS, 8'h00);
			check({7'h00, irq_line}, 8'h01);
		end
		// an event landing while the read clears must re-pull the line
		u_host.write_reg(`OFS_MASK, 8'h03);
		lv[0] = 1'b0;
		wait_irq(1'b0);
		fork
			rdc(`OFS_FLAGS, 8'h02);
			begin
				// 29th scl fall ends the read address ack: the clearing clk
				repeat (29) @(negedge scl);
				lv[0] = 1'b1;
				repeat (2) @(negedge clk_sys_i);
				check({7'h00, irq_line}, 8'h01);
				@(negedge clk_sys_i);
				check({7'h00, irq_line}, 8'h00);
			end
		join
		wait_irq(1'b0);
		rdc(`OFS_FLAGS, 8'h01);
		u_host.write_reg(`OFS_MASK, 8'h40);
		u_host.write_reg(`OFS_CONV_CTRL, 8'h08);
		repeat (40) @(negedge clk_sys_i);
		rdc(`OFS_CONV_CTRL, 8'h08);
		u_host.write_reg(`OFS_CONV_CTRL, 8'h05);
		check({5'h00, adc_en, adc_src}, 8'h05);
		u_host.write_reg(`OFS_CONV_CTRL, 8'h0D);
		wait_irq(1'b0);
		rdc(`OFS_RESULT, 8'hA5);
		rdc(`OFS_CONV_CTRL, 8'h1D);
		rdc(`OFS_FLAGS, 8'h40);
		adc_code = 8'h3C;
		adc_ovf = 1'b1;
		// start already high: no rising edge, so nothing may begin
		u_host.write_reg(`OFS_CONV_CTRL, 8'h0D);
		repeat (40) @(negedge clk_sys_i);
		check({7'h00, irq_line}, 8'h01);
		u_host.write_reg(`OFS_CONV_CTRL, 8'h05);
		u_host.write_reg(`OFS_CONV_CTRL, 8'h0D);
		wait_irq(1'b0);
		rdc(`OFS_CONV_CTRL, 8'h3D);
		u_host.write_reg(`OFS_RESULT, 8'hFF);
		rdc(`OFS_RESULT, 8'h3C);
		u_host.write_reg(`OFS_CONV_CTRL, 8'hF3);
		rdc(`OFS_CONV_CTRL, 8'hF3);
		check({3'h0, v_rng, i_rng, adc_en, adc_src}, 8'h1B);
		rdc(`OFS_FLAGS, 8'h40);
		u_host.write_reg(`OFS_FLAGS, 8'hFF);
		rdc(`OFS_FLAGS, 8'h00);
		// second reset with all levels high: each fires once, masked
		rst_i = 1'b1;
		repeat (3) @(negedge clk_sys_i);
		rst_i = 1'b0;
		repeat (3) @(negedge clk_sys_i);
		rdc(`OFS_MASK, 8'h00);
		rdc(`OFS_FLAGS, 8'hB5);
		check({7'h00, irq_line}, 8'h01);
		summarize();
	end
endmodule
`default_nettype wire
